// ---- fsap_status_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module fsap_status_ctrl #(
	parameter int ADDR_W = 21
) (
	// Clock and power-up reset
	input wire logic clk,
	input wire logic reset_n,
	// Decoded command from the serial front end
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic [ADDR_W-1:0] cmd_addr,
	input wire logic [fsap_pkg::STATUS_W-1:0] cmd_wdata,
	// Non-volatile image restore after power-up
	input wire logic nv_load,
	input wire logic [fsap_pkg::STATUS_W-1:0] nv_image,
	// Array engine and pins
	input wire logic op_done,
	input wire logic wp_n,
	// Status and array control
	output logic [fsap_pkg::STATUS_W-1:0] status_reg,
	output logic op_start_reg,
	output fsap_pkg::fsap_op_t op_kind_reg,
	output logic [ADDR_W-1:0] op_addr_reg,
	output logic suspend_req_reg,
	output logic resume_req_reg,
	output logic quad_io_en_reg,
	output logic hold_en_reg,
	output logic sec_lock_reg
);
	import fsap_pkg::*;

	////////////////////////////////////////////////////////////////////////////////////////////
	logic busy_reg, busy_next, wel_reg, wel_next, qe_reg, qe_next, lb_reg, lb_next;
	logic cmp_reg, cmp_next, hpf_reg, hpf_next, sus_reg, sus_next;
	logic [BP_W-1:0] bp_reg, bp_next;
	logic [1:0] srp_reg, srp_next;
	logic [STATUS_W-1:0] status_next;
	logic op_start_next, suspend_req_next, resume_req_next;
	fsap_op_t op_kind_next, cur_op_reg, cur_op_next;
	logic [ADDR_W-1:0] op_addr_next;
	logic addr_protected, is_prog, is_erase, is_chip, is_array, sr_write_ok, wp_low;

	fsap_protect_dec #(.ADDR_W(ADDR_W)) u_dec (
		.block_protect_field(bp_reg),
		.protect_complement(cmp_reg),
		.addr(cmd_addr),
		.protected_o(addr_protected)
	);

	////////////////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		is_prog = (cmd_code == CMD_PAGE_PROGRAM) || (cmd_code == CMD_QUAD_PROGRAM);
		is_erase = (cmd_code == CMD_SECTOR_ERASE) || (cmd_code == CMD_BLOCK_ERASE_32)
			|| (cmd_code == CMD_BLOCK_ERASE_64);
		is_chip = (cmd_code == CMD_CHIP_ERASE_A) || (cmd_code == CMD_CHIP_ERASE_B);
		is_array = is_prog | is_erase | is_chip;
		// Protect pin only acts while it is not a data line
		wp_low = ~wp_n & ~qe_reg;
		unique case (srp_reg)
			SRP_SOFT: sr_write_ok = 1'b1; // see R08
			SRP_HW: sr_write_ok = ~wp_low; // see R09 see R06
			default: sr_write_ok = 1'b0; // see R10 see R11
		endcase
		sr_write_ok = sr_write_ok & wel_reg & ~busy_reg; // see R04
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		busy_next = busy_reg;
		wel_next = wel_reg;
		bp_next = bp_reg;
		srp_next = srp_reg;
		qe_next = qe_reg;
		lb_next = lb_reg;
		cmp_next = cmp_reg;
		hpf_next = hpf_reg;
		sus_next = sus_reg;
		cur_op_next = cur_op_reg;
		op_start_next = 1'b0;
		op_kind_next = op_kind_reg;
		op_addr_next = op_addr_reg;
		suspend_req_next = 1'b0;
		resume_req_next = 1'b0;
		if (op_done && busy_reg) begin
			busy_next = 1'b0; // see R03
			cur_op_next = FSAP_OP_NONE;
		end
		if (nv_load && !busy_reg) begin
			bp_next = nv_image[BP_LSB +: BP_W];
			// Lock-down does not survive a power cycle
			srp_next = ({nv_image[SRP_HI_BIT], nv_image[SRP_LO_BIT]} == SRP_LOCKDOWN) ?
				SRP_SOFT : {nv_image[SRP_HI_BIT], nv_image[SRP_LO_BIT]}; // see R10
			qe_next = nv_image[QE_BIT];
			lb_next = nv_image[LB_BIT];
			cmp_next = nv_image[CMP_BIT];
		end else if (cmd_valid && !busy_reg) begin
			if (cmd_code == CMD_WRITE_ENABLE) begin
				wel_next = 1'b1;
			end else if (cmd_code == CMD_WRITE_DISABLE) begin
				wel_next = 1'b0; // see R18
			end else if (cmd_code == CMD_STATUS_WRITE) begin
				wel_next = 1'b0; // see R18
				if (sr_write_ok) begin
					bp_next = cmd_wdata[BP_LSB +: BP_W]; // see R05
					srp_next = {cmd_wdata[SRP_HI_BIT], cmd_wdata[SRP_LO_BIT]};
					qe_next = cmd_wdata[QE_BIT]; // see R12
					lb_next = lb_reg | cmd_wdata[LB_BIT]; // see R14
					cmp_next = cmd_wdata[CMP_BIT]; // see R02
					busy_next = 1'b1; // see R03
				end
			end else if (is_array) begin
				wel_next = 1'b0; // see R18
				if (wel_reg && (is_chip ? (bp_reg[2:0] == 3'h0 && !cmp_reg) : // see R07
					!addr_protected)) begin // see R05 see R21
					busy_next = 1'b1;
					op_start_next = 1'b1;
					op_kind_next = is_chip ? FSAP_OP_CHIP :
						(is_prog ? FSAP_OP_PROGRAM : FSAP_OP_ERASE);
					op_addr_next = cmd_addr;
					cur_op_next = op_kind_next;
				end
			end else if (cmd_code == CMD_HIGH_PERF) begin
				hpf_next = 1'b1; // see R15
			end else if (cmd_code == CMD_RELEASE) begin
				hpf_next = 1'b0; // see R15
			end else if (cmd_code == CMD_RESUME && sus_reg) begin
				sus_next = 1'b0; // see R16
				busy_next = 1'b1;
				resume_req_next = 1'b1;
			end
		end else if (cmd_valid && cmd_code == CMD_SUSPEND && busy_reg && !op_done
			&& cur_op_reg != FSAP_OP_NONE) begin
			// Only array operations can be parked
			sus_next = 1'b1; // see R16
			busy_next = 1'b0;
			suspend_req_next = 1'b1;
		end
		status_next = '0;
		status_next[BUSY_BIT] = busy_next; // see R20
		status_next[WEL_BIT] = wel_next; // see R04
		status_next[BP_LSB +: BP_W] = bp_next;
		status_next[SRP_LO_BIT] = srp_next[0];
		status_next[SRP_HI_BIT] = srp_next[1];
		status_next[QE_BIT] = qe_next;
		status_next[LB_BIT] = lb_next;
		status_next[HPF_BIT] = hpf_next;
		status_next[CMP_BIT] = cmp_next;
		status_next[SUS_BIT] = sus_next;
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_reg <= BIT_RESET;
			wel_reg <= BIT_RESET; // see R18
			bp_reg <= BP_RESET;
			srp_reg <= SRP_RESET;
			qe_reg <= BIT_RESET;
			lb_reg <= BIT_RESET;
			cmp_reg <= BIT_RESET;
			hpf_reg <= BIT_RESET;
			sus_reg <= BIT_RESET;
			cur_op_reg <= FSAP_OP_NONE;
			status_reg <= '0;
			op_start_reg <= 1'b0;
			op_kind_reg <= FSAP_OP_NONE;
			op_addr_reg <= '0;
			suspend_req_reg <= 1'b0;
			resume_req_reg <= 1'b0;
			quad_io_en_reg <= 1'b0;
			hold_en_reg <= 1'b1;
			sec_lock_reg <= 1'b0;
		end else begin
			busy_reg <= busy_next;
			wel_reg <= wel_next;
			bp_reg <= bp_next;
			srp_reg <= srp_next;
			qe_reg <= qe_next;
			lb_reg <= lb_next;
			cmp_reg <= cmp_next;
			hpf_reg <= hpf_next;
			sus_reg <= sus_next;
			cur_op_reg <= cur_op_next;
			status_reg <= status_next;
			op_start_reg <= op_start_next;
			op_kind_reg <= op_kind_next;
			op_addr_reg <= op_addr_next;
			suspend_req_reg <= suspend_req_next;
			resume_req_reg <= resume_req_next;
			quad_io_en_reg <= qe_next; // see R12
			hold_en_reg <= ~qe_next; // see R19
			sec_lock_reg <= lb_next; // see R14
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	AST_WEL_GATE: assert property (@(posedge clk) disable iff (!reset_n) // see R04
		cmd_valid && !wel_reg && !busy_reg && !nv_load && is_array
		|=> !op_start_reg && !busy_reg)
		else $error("array command accepted with write latch clear");
	AST_PROT_DISCARD: assert property (@(posedge clk) disable iff (!reset_n) // see R21
		cmd_valid && !busy_reg && !nv_load && (is_prog || is_erase) && addr_protected
		|=> !op_start_reg && !status_reg[BUSY_BIT])
		else $error("protected target started an operation");
	AST_CHIP_GUARD: assert property (@(posedge clk) disable iff (!reset_n) // see R07
		op_start_reg && op_kind_reg == FSAP_OP_CHIP |-> $past(bp_reg[2:0]) == 3'h0
		&& !$past(cmp_reg))
		else $error("chip erase ran under protection");
	AST_HW_LOCK: assert property (@(posedge clk) disable iff (!reset_n) // see R09
		cmd_valid && cmd_code == CMD_STATUS_WRITE && srp_reg == SRP_HW && wp_low && !nv_load
		&& !busy_reg |=> $stable(bp_reg) && $stable(cmp_reg) && !busy_reg)
		else $error("status changed under hardware protection");
	AST_LOCKED_MODES: assert property (@(posedge clk) disable iff (!reset_n) // see R10
		srp_reg[1] && !nv_load |=> $stable(bp_reg) && $stable(qe_reg) && $stable(srp_reg))
		else $error("status changed while locked");
	AST_LB_STICKY: assert property (@(posedge clk) disable iff (!reset_n) // see R14
		lb_reg |=> lb_reg ##1 sec_lock_reg)
		else $error("security lock cleared");
	AST_STATUS_WRITE_CMD_BUSY: assert property (@(posedge clk) disable iff (!reset_n) // see R03
		cmd_valid && cmd_code == CMD_STATUS_WRITE && sr_write_ok && !nv_load
		|=> status_reg[BUSY_BIT] && !status_reg[WEL_BIT])
		else $error("status write did not show busy");
	AST_WEL_CLEAR: assert property (@(posedge clk) disable iff (!reset_n) // see R18
		cmd_valid && !busy_reg && !nv_load && (cmd_code == CMD_WRITE_DISABLE || is_array)
		|=> !wel_reg ##0 !status_reg[WEL_BIT])
		else $error("write latch not cleared");
	AST_SUSPEND: assert property (@(posedge clk) disable iff (!reset_n) // see R16
		suspend_req_reg |-> sus_reg && status_reg[SUS_BIT] && !status_reg[BUSY_BIT])
		else $error("suspend flag not set");
	AST_QUAD_PINS: assert property (@(posedge clk) disable iff (!reset_n) // see R19
		quad_io_en_reg != hold_en_reg)
		else $error("hold active with quad data lines");
endmodule
`default_nettype wire

// ---- fsap_pkg.sv ----
// Function
// R01: Complement set protects exactly the range left open by the same protect field.
// R02: Complement bit lives at status bit 14, writable, defaults to zero.
// R03: Busy flag reads one during program, erase or status write, else zero.
// R04: Write latch clear refuses status write, program and erase; flag mirrors latch.
// R05: Protect field loads only by status write; its region rejects program and erase.
// R06: Protect field cannot change while hardware protection is in force.
// R07: Chip erase runs only with protect bits two to zero and complement all zero.
// R08: Status protect 0,0 allows status write whenever write latch set.
// R09: Status protect 0,1 locks status while protect pin low, allows when high.
// R10: Status protect 1,0 refuses status write until power cycle, which returns 0,0.
// R11: Status protect 1,1 refuses all status writes permanently.
// R12: Quad enable defaults zero keeping pin functions; one turns pins into data lines.
// R13: Host keeps quad enable zero when protect or hold pin is tied.
// R14: Security lock at bit 10 defaults zero; once set it never clears.
// R15: High performance flag reads one only in high performance mode, default zero.
// R16: Suspend flag at bit 15 is read-only, set by suspend, cleared by resume.
// R17: Complement clear makes protect field select the directly protected region.
// R18: Write latch clears on power-up, disable, status write, program and erases.
// R19: Hold function available only while quad enable is zero.
// R20: Low status byte: busy, write latch, protect field, status protect low.
// R21: Protected program or erase is discarded without busy and without array change.
package fsap_pkg;
	// Status bit positions
	localparam int BUSY_BIT = 0;
	localparam int WEL_BIT = 1;
	localparam int BP_LSB = 2;
	localparam int SRP_LO_BIT = 7;
	localparam int SRP_HI_BIT = 8;
	localparam int QE_BIT = 9;
	localparam int LB_BIT = 10;
	localparam int HPF_BIT = 13;
	localparam int CMP_BIT = 14;
	localparam int SUS_BIT = 15;
	localparam int STATUS_W = 16;
	localparam int BP_W = 5;
	// Status protect modes
	localparam logic [1:0] SRP_SOFT = 2'h0;
	localparam logic [1:0] SRP_HW = 2'h1;
	localparam logic [1:0] SRP_LOCKDOWN = 2'h2;
	// Reset values
	localparam logic [BP_W-1:0] BP_RESET = 5'h00;
	localparam logic [1:0] SRP_RESET = 2'h0;
	localparam logic BIT_RESET = 1'b0;
	// Protect decode shifts
	localparam logic [4:0] SECTOR_SHIFT_M1 = 5'h0B;
	localparam logic [4:0] HALF_BLOCK_SHIFT = 5'h0F;
	localparam logic [4:0] BLOCK_SHIFT_M1 = 5'h0F;
	// Command codes
	localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
	localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] CMD_QUAD_PROGRAM = 8'h32;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] CMD_BLOCK_ERASE_32 = 8'h52;
	localparam logic [7:0] CMD_BLOCK_ERASE_64 = 8'hD8;
	localparam logic [7:0] CMD_CHIP_ERASE_A = 8'h60;
	localparam logic [7:0] CMD_CHIP_ERASE_B = 8'hC7;
	localparam logic [7:0] CMD_SUSPEND = 8'h75;
	localparam logic [7:0] CMD_RESUME = 8'h7A;
	localparam logic [7:0] CMD_HIGH_PERF = 8'hA3;
	localparam logic [7:0] CMD_RELEASE = 8'hAB;
	typedef enum logic [1:0] {FSAP_OP_NONE, FSAP_OP_PROGRAM, FSAP_OP_ERASE, FSAP_OP_CHIP}
		fsap_op_t;
endpackage

// ---- fsap_protect_dec.sv ----
`timescale 1ns/1ps
`default_nettype none
module fsap_protect_dec #(
	parameter int ADDR_W = 21
) (
	// Protection setting
	input wire logic [fsap_pkg::BP_W-1:0] block_protect_field,
	input wire logic protect_complement,
	// Target
	input wire logic [ADDR_W-1:0] addr,
	output logic protected_o
);
	import fsap_pkg::*;
	localparam logic [ADDR_W:0] ARRAY_TOP = {1'b1, {ADDR_W{1'b0}}};
	logic [4:0] shift;
	logic [ADDR_W:0] span;
	logic none_sel;
	logic all_sel;
	logic hit;
	always_comb begin
		none_sel = (block_protect_field[2:0] == 3'h0);
		all_sel = (block_protect_field[2:1] == 2'h3);
		// Upper field bit picks 4KB-based sector granules, or 32KB half blocks when bit 2 is set, otherwise 64KB blocks
		if (block_protect_field[4]) begin
			if (block_protect_field[2]) begin
				shift = HALF_BLOCK_SHIFT;
			end else begin
				shift = SECTOR_SHIFT_M1 + {3'h0, block_protect_field[1:0]};
			end
		end else begin
			shift = BLOCK_SHIFT_M1 + {2'h0, block_protect_field[2:0]};
		end
		span = (ADDR_W+1)'(1) << shift;
		if (block_protect_field[3]) begin
			hit = ({1'b0, addr} < span);
		end else begin
			hit = ({1'b0, addr} >= (ARRAY_TOP - span));
		end
		// Complement inverts the selected region
		protected_o = (all_sel | (~none_sel & hit)) ^ protect_complement; // see R01 see R17
	end
endmodule
`default_nettype wire

// ---- fsap_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fsap_host_model #(
	parameter int ADDR_W = 21
) (
	// Clock
	input wire logic clk,
	// Framed command towards the device
	output var logic cmd_valid,
	output var logic [7:0] cmd_code,
	output var logic [ADDR_W-1:0] cmd_addr,
	output var logic [15:0] cmd_wdata
);
	// Quad enable stays clear unless the pins are free wired
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		cmd_addr = '0;
		cmd_wdata = 16'h0000;
	end
	////////////////////////////////////////////////////////////////////////////////
	// One command a call, launched and released just after an edge
	task automatic issue(input logic [7:0] c, input logic [ADDR_W-1:0] a, input logic [15:0] d);
		@(posedge clk);
		#1;
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_addr = a;
		cmd_wdata = d;
		@(posedge clk);
		#1;
		// Released lines show the inverse, not a stale copy
		cmd_valid = 1'b0;
		cmd_code = ~c;
		cmd_addr = ~a;
		cmd_wdata = ~d;
	endtask
endmodule
`default_nettype wire

// ---- tb_flash_status_and_array_protection.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_flash_status_and_array_protection;
	import fsap_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic nv_load = 1'b0;
	logic op_done = 1'b0;
	logic wp_n = 1'b1;
	logic [15:0] nv_image = 16'h0000;
	logic cmd_valid;
	logic [7:0] cmd_code;
	logic [20:0] cmd_addr;
	logic [15:0] cmd_wdata;
	logic [15:0] status_reg;
	logic op_start_reg;
	logic quad_io_en_reg;
	logic hold_en_reg;
	logic sec_lock_reg;
	logic [20:0] op_addr;
	logic suspend_req;
	logic resume_req;
	fsap_op_t op_kind;
	int error_cnt = 0;
	int checked = 0;
	int cycles = 0;
	always #5 clk = ~clk;
	fsap_host_model #(.ADDR_W(21)) host (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata));
	fsap_status_ctrl #(.ADDR_W(21)) dut (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .nv_load(nv_load),
		.nv_image(nv_image), .op_done(op_done), .wp_n(wp_n), .status_reg(status_reg),
		.op_start_reg(op_start_reg), .op_kind_reg(op_kind), .op_addr_reg(op_addr),
		.suspend_req_reg(suspend_req), .resume_req_reg(resume_req),
		.quad_io_en_reg(quad_io_en_reg), .hold_en_reg(hold_en_reg),
		.sec_lock_reg(sec_lock_reg));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			error_cnt++;
			final_report();
		end
	end
	task automatic reset_dut();
		reset_n = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		reset_n = 1'b1;
	endtask
	task automatic done_pulse();
		@(posedge clk);
		#1;
		op_done = 1'b1;
		@(posedge clk);
		#1;
		op_done = 1'b0;
	endtask
	// Power-up restore of the stored image
	task automatic nv_restore(input logic [15:0] d);
		@(posedge clk);
		#1;
		nv_load = 1'b1;
		nv_image = d;
		@(posedge clk);
		#1;
		nv_load = 1'b0;
	endtask
	// Enable, then write status, then finish the write
	task automatic wsr(input logic [15:0] d);
		host.issue(CMD_WRITE_ENABLE, 21'h000000, 16'h0000);
		host.issue(CMD_STATUS_WRITE, 21'h000000, d);
		done_pulse();
	endtask
	// Enable, then issue one array command and judge its launch
	task automatic arr(input logic [7:0] c, input logic [20:0] a, input logic ok);
		host.issue(CMD_WRITE_ENABLE, 21'h000000, 16'h0000);
		host.issue(c, a, 16'h0000);
		chk(op_start_reg, ok);
		chk(status_reg[1:0], {1'b0, ok});
		if (ok) begin
			chk(op_addr, a);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk(status_reg, 16'h0000);
		chk({quad_io_en_reg, hold_en_reg}, 2'h1);
		$display("test reset done");
	endtask
	task automatic t_wel();
		host.issue(CMD_WRITE_ENABLE, 21'h000000, 16'h0000);
		chk(status_reg[1], 1'b1);
		host.issue(CMD_WRITE_DISABLE, 21'h000000, 16'h0000);
		chk(status_reg[1], 1'b0);
		host.issue(CMD_PAGE_PROGRAM, 21'h000000, 16'h0000);
		chk(op_start_reg, 1'b0);
		$display("test write latch done");
	endtask
	task automatic t_protect();
		wsr(16'h0004);
		chk(status_reg, 16'h0004);
		arr(CMD_PAGE_PROGRAM, 21'h1F0000, 1'b0);
		arr(CMD_SECTOR_ERASE, 21'h1EFFFF, 1'b1);
		done_pulse();
		chk(status_reg[0], 1'b0);
		wsr(16'h4004);
		arr(CMD_BLOCK_ERASE_64, 21'h1EFFFF, 1'b0);
		arr(CMD_QUAD_PROGRAM, 21'h1F0000, 1'b1);
		done_pulse();
		arr(CMD_CHIP_ERASE_A, 21'h000000, 1'b0);
		wsr(16'h0018);
		arr(CMD_BLOCK_ERASE_32, 21'h000000, 1'b0);
		wsr(16'h0064);
		arr(CMD_PAGE_PROGRAM, 21'h000FFF, 1'b0);
		arr(CMD_PAGE_PROGRAM, 21'h001000, 1'b1);
		done_pulse();
		wsr(16'h4064);
		arr(CMD_SECTOR_ERASE, 21'h001000, 1'b0);
		arr(CMD_SECTOR_ERASE, 21'h000FFF, 1'b1);
		done_pulse();
		wsr(16'h4044);
		arr(CMD_PAGE_PROGRAM, 21'h1FEFFF, 1'b0);
		arr(CMD_PAGE_PROGRAM, 21'h1FF000, 1'b1);
		done_pulse();
		wsr(16'h4018);
		arr(CMD_SECTOR_ERASE, 21'h000000, 1'b1);
		done_pulse();
		wsr(16'h4000);
		arr(CMD_CHIP_ERASE_A, 21'h000000, 1'b0);
		wsr(16'h0000);
		arr(CMD_CHIP_ERASE_B, 21'h000000, 1'b1);
		chk(op_kind, FSAP_OP_CHIP);
		done_pulse();
		$display("test protect done");
	endtask
	task automatic t_srp();
		wsr(16'h0080);
		wp_n = 1'b0;
		wsr(16'h0084);
		chk(status_reg[8:2], 7'h20);
		wp_n = 1'b1;
		wsr(16'h0084);
		chk(status_reg[8:2], 7'h21);
		wsr(16'h0100);
		wsr(16'h0004);
		chk(status_reg[8:2], 7'h40);
		reset_dut();
		chk(status_reg, 16'h0000);
		nv_restore(16'h0100);
		chk(status_reg[8:7], 2'h0);
		wsr(16'h0004);
		chk(status_reg[6:2], 5'h01);
		wsr(16'h0000);
		wsr(16'h0180);
		wsr(16'h0004);
		chk(status_reg[8:2], 7'h60);
		reset_dut();
		nv_restore(16'h0180);
		chk(status_reg[8:7], 2'h3);
		wsr(16'h0000);
		chk(status_reg[8:2], 7'h60);
		reset_dut();
		$display("test status protect done");
	endtask
	task automatic t_suspend();
		arr(CMD_PAGE_PROGRAM, 21'h000100, 1'b1);
		host.issue(CMD_SUSPEND, 21'h000000, 16'h0000);
		chk({status_reg[15], status_reg[0]}, 2'h2);
		chk(suspend_req, 1'b1);
		host.issue(CMD_RESUME, 21'h000000, 16'h0000);
		chk({status_reg[15], status_reg[0]}, 2'h1);
		chk(resume_req, 1'b1);
		done_pulse();
		$display("test suspend done");
	endtask
	task automatic t_misc();
		wsr(16'hA200);
		chk(status_reg[15:13], 3'h0);
		chk({quad_io_en_reg, hold_en_reg}, 2'h2);
		wsr(16'h0400);
		wsr(16'h0000);
		chk({sec_lock_reg, status_reg[10]}, 2'h3);
		host.issue(CMD_HIGH_PERF, 21'h000000, 16'h0000);
		chk(status_reg[13], 1'b1);
		host.issue(CMD_RELEASE, 21'h000000, 16'h0000);
		chk(status_reg[13], 1'b0);
		$display("test misc done");
	endtask
	initial begin
		reset_dut();
		t_reset();
		t_wel();
		t_protect();
		t_srp();
		t_suspend();
		t_misc();
		final_report();
	end
endmodule
`default_nettype wire
